// File: rtl/lpog_regs.svh
// constants for the pad override and tail gamma register bank
// assumes inclusion by bare name from rtl files
`ifndef LPOG_REGS_SVH
`define LPOG_REGS_SVH
`define LPOG_OFS_GAMMA_231 8'hae
`define LPOG_OFS_GAMMA_239 8'haf
`define LPOG_OFS_GAMMA_243 8'hb0
`define LPOG_OFS_GAMMA_247 8'hb1
`define LPOG_OFS_GAMMA_251 8'hb2
`define LPOG_OFS_GAMMA_255 8'hb3
`define LPOG_OFS_PAD_MAP_RES 8'hb6
`define LPOG_OFS_PAD_LANE_CNT 8'hb7
`define LPOG_RST_GAMMA_231 8'h45
`define LPOG_RST_GAMMA_239 8'h1d
`define LPOG_RST_GAMMA_243 8'h23
`define LPOG_RST_GAMMA_247 8'h52
`define LPOG_RST_GAMMA_251 8'h63
`define LPOG_RST_GAMMA_255 8'h39
`define LPOG_RST_PAD 8'h00
`define LPOG_MASK_GAMMA7 8'h7f
`define LPOG_MASK_GAMMA6 8'h3f
`define LPOG_MASK_PAD_MAP_RES 8'hfb
`define LPOG_MASK_PAD_LANE_CNT 8'h03
`define LPOG_BIT_MAP_EN 7
`define LPOG_BIT_MAP_SEL_HI 6
`define LPOG_BIT_MAP_SEL_LO 4
`define LPOG_BIT_RES_EN 3
`define LPOG_BIT_RES_SEL_HI 1
`define LPOG_BIT_RES_SEL_LO 0
`define LPOG_BIT_CNT_EN 1
`define LPOG_BIT_CNT_SEL 0
`define LPOG_WIDTH_800 10'h320
`define LPOG_WIDTH_768 10'h300
`define LPOG_WIDTH_720 10'h2d0
`define LPOG_WIDTH_640 10'h280
`endif

// File: rtl/lpog_pkg.sv
// types for the pad override and tail gamma register bank
// assumes nothing beyond a systemverilog compiler
package lpog_pkg;
  typedef logic [7:0] lpog_byte_t;
  typedef logic [2:0] lpog_map_t;
  typedef logic [1:0] lpog_lane_idx_t;
  typedef enum logic [1:0] {
    LPOG_RES_800,
    LPOG_RES_768,
    LPOG_RES_720,
    LPOG_RES_640
  } lpog_res_t;
endpackage

// File: rtl/lpog_sync.sv
// two flop synchroniser for strap pins
// assumes pins are asynchronous to clk_sys
`timescale 1ns/10ps
`default_nettype none
module lpog_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  // first stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end
  assign pin_sync = sync_reg;
endmodule
`default_nettype wire

// File: rtl/lpog_bank.sv
// register bank: tail positive gamma levels and pad override controls
// assumes a single-cycle strobe master on clk_sys; strap pins are asynchronous
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "lpog_regs.svh"
module lpog_bank
  import lpog_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] lane_map_strap_pins,
  input wire logic [1:0] res_strap_pins,
  input wire logic lane_count_strap_pin,
  output logic [6:0] pos_gamma_231,
  output logic [5:0] pos_gamma_239,
  output logic [5:0] pos_gamma_243,
  output logic [6:0] pos_gamma_247,
  output logic [6:0] pos_gamma_251,
  output logic [5:0] pos_gamma_255,
  output logic [7:0] lane_src_sel,
  output logic lane_pn_swap,
  output logic clock_lane_pair_swap,
  output logic [1:0] res_mode,
  output logic [9:0] h_columns,
  output logic two_lane_mode
);
  lpog_byte_t gamma_231_reg, gamma_239_reg, gamma_243_reg;
  lpog_byte_t gamma_247_reg, gamma_251_reg, gamma_255_reg;
  lpog_byte_t pad_map_res_reg, pad_lane_cnt_reg;
  lpog_byte_t rdata_reg, rdata_next;
  logic [2:0] map_pins_sync;
  logic [1:0] res_pins_sync;
  logic cnt_pin_sync;
  lpog_map_t map_eff;
  lpog_res_t res_eff;
  logic cnt_eff;
  logic [7:0] lane_src_reg;
  logic pn_swap_reg;
  logic [1:0] res_mode_reg;
  logic [9:0] h_cols_reg;
  logic two_lane_reg;

  // lane source for pin pairs d0..d3, two bits each, d0 lowest
  function automatic logic [7:0] lpog_lane_order(input logic [1:0] ord);
    case (ord)
      2'h0: lpog_lane_order = {2'h0, 2'h1, 2'h2, 2'h3};
      2'h1: lpog_lane_order = {2'h3, 2'h2, 2'h1, 2'h0};
      2'h2: lpog_lane_order = {2'h2, 2'h1, 2'h0, 2'h3};
      default: lpog_lane_order = {2'h3, 2'h0, 2'h1, 2'h2};
    endcase
  endfunction

  function automatic logic [9:0] lpog_columns(input lpog_res_t r);
    case (r)
      LPOG_RES_800: lpog_columns = `LPOG_WIDTH_800;
      LPOG_RES_768: lpog_columns = `LPOG_WIDTH_768;
      LPOG_RES_720: lpog_columns = `LPOG_WIDTH_720;
      LPOG_RES_640: lpog_columns = `LPOG_WIDTH_640;
      default: lpog_columns = `LPOG_WIDTH_800;
    endcase
  endfunction

  lpog_sync #(.WIDTH(6)) u_strap_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in({lane_map_strap_pins, res_strap_pins, lane_count_strap_pin}),
    .pin_sync({map_pins_sync, res_pins_sync, cnt_pin_sync})
  );

  // no power mode input: access never gated
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gamma_231_reg <= `LPOG_RST_GAMMA_231;
      gamma_239_reg <= `LPOG_RST_GAMMA_239;
      gamma_243_reg <= `LPOG_RST_GAMMA_243;
      gamma_247_reg <= `LPOG_RST_GAMMA_247;
      gamma_251_reg <= `LPOG_RST_GAMMA_251;
      gamma_255_reg <= `LPOG_RST_GAMMA_255;
    end else if (reg_wr) begin
      case (reg_addr)
        `LPOG_OFS_GAMMA_231: gamma_231_reg <= reg_wdata & `LPOG_MASK_GAMMA7;
        `LPOG_OFS_GAMMA_239: gamma_239_reg <= reg_wdata & `LPOG_MASK_GAMMA6;
        `LPOG_OFS_GAMMA_243: gamma_243_reg <= reg_wdata & `LPOG_MASK_GAMMA6;
        `LPOG_OFS_GAMMA_247: gamma_247_reg <= reg_wdata & `LPOG_MASK_GAMMA7;
        `LPOG_OFS_GAMMA_251: gamma_251_reg <= reg_wdata & `LPOG_MASK_GAMMA7;
        `LPOG_OFS_GAMMA_255: gamma_255_reg <= reg_wdata & `LPOG_MASK_GAMMA6;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pad_map_res_reg <= `LPOG_RST_PAD;
      pad_lane_cnt_reg <= `LPOG_RST_PAD;
    end else if (reg_wr) begin
      if (reg_addr == `LPOG_OFS_PAD_MAP_RES) begin
        pad_map_res_reg <= reg_wdata & `LPOG_MASK_PAD_MAP_RES;
      end
      if (reg_addr == `LPOG_OFS_PAD_LANE_CNT) begin
        pad_lane_cnt_reg <= reg_wdata & `LPOG_MASK_PAD_LANE_CNT;
      end
    end
  end

  // unmapped offsets read zero
  always_comb begin
    case (reg_addr)
      `LPOG_OFS_GAMMA_231: rdata_next = gamma_231_reg;
      `LPOG_OFS_GAMMA_239: rdata_next = gamma_239_reg;
      `LPOG_OFS_GAMMA_243: rdata_next = gamma_243_reg;
      `LPOG_OFS_GAMMA_247: rdata_next = gamma_247_reg;
      `LPOG_OFS_GAMMA_251: rdata_next = gamma_251_reg;
      `LPOG_OFS_GAMMA_255: rdata_next = gamma_255_reg;
      `LPOG_OFS_PAD_MAP_RES: rdata_next = pad_map_res_reg;
      `LPOG_OFS_PAD_LANE_CNT: rdata_next = pad_lane_cnt_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  always_comb begin
    if (pad_map_res_reg[`LPOG_BIT_MAP_EN]) begin
      map_eff = pad_map_res_reg[`LPOG_BIT_MAP_SEL_HI:`LPOG_BIT_MAP_SEL_LO];
    end else begin
      map_eff = map_pins_sync;
    end
    if (pad_map_res_reg[`LPOG_BIT_RES_EN]) begin
      res_eff = lpog_res_t'(pad_map_res_reg[`LPOG_BIT_RES_SEL_HI:`LPOG_BIT_RES_SEL_LO]);
    end else begin
      res_eff = lpog_res_t'(res_pins_sync);
    end
    if (pad_lane_cnt_reg[`LPOG_BIT_CNT_EN]) begin
      cnt_eff = pad_lane_cnt_reg[`LPOG_BIT_CNT_SEL];
    end else begin
      cnt_eff = cnt_pin_sync;
    end
  end

  // registered outputs keep pad steering glitch free
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      lane_src_reg <= 8'h1b;
      pn_swap_reg <= 1'b0;
      res_mode_reg <= 2'h0;
      h_cols_reg <= `LPOG_WIDTH_800;
      two_lane_reg <= 1'b0;
    end else begin
      lane_src_reg <= lpog_lane_order(map_eff[2:1]);
      pn_swap_reg <= map_eff[0];
      res_mode_reg <= res_eff;
      h_cols_reg <= lpog_columns(res_eff);
      two_lane_reg <= cnt_eff;
    end
  end

  assign reg_rdata = rdata_reg;
  assign pos_gamma_231 = gamma_231_reg[6:0];
  assign pos_gamma_239 = gamma_239_reg[5:0];
  assign pos_gamma_243 = gamma_243_reg[5:0];
  assign pos_gamma_247 = gamma_247_reg[6:0];
  assign pos_gamma_251 = gamma_251_reg[6:0];
  assign pos_gamma_255 = gamma_255_reg[5:0];
  assign lane_src_sel = lane_src_reg;
  assign lane_pn_swap = pn_swap_reg;
  assign clock_lane_pair_swap = pn_swap_reg;
  assign res_mode = res_mode_reg;
  assign h_columns = h_cols_reg;
  assign two_lane_mode = two_lane_reg;
endmodule
`default_nettype wire

// File: tb/lpog_strap_model.sv
// board strap model for the bank's strap inputs
// assumes a static setting from the bench
`timescale 1ns/10ps
`default_nettype none
module lpog_strap_model (
  input wire logic [5:0] strap_cfg,
  output logic [2:0] lane_map_strap_pins,
  output logic [1:0] res_strap_pins,
  output logic lane_count_strap_pin
);
  // firm levels only, no floating pin modelled
  assign lane_map_strap_pins = strap_cfg[5:3];
  assign res_strap_pins = strap_cfg[2:1];
  assign lane_count_strap_pin = strap_cfg[0];
endmodule
`default_nettype wire

// File: tb/lpog_bank_assertions.sv
// checker for the bank's register port and pad outputs
// assumes it is bound to lpog_bank
`timescale 1ns/10ps
`default_nettype none
module lpog_bank_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic lane_pn_swap,
  input wire logic clock_lane_pair_swap,
  input wire logic [1:0] res_mode,
  input wire logic [9:0] h_columns
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_rd_only; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data outside read cycle");
  property p_g7; reg_rd && reg_addr == 8'hae |=> !reg_rdata[7]; endproperty
  a_g7: assert property (p_g7) else $error("seven-bit gamma top bit set");
  property p_g6; reg_rd && reg_addr == 8'haf |=> reg_rdata[7:6] == 2'h0; endproperty
  a_g6: assert property (p_g6) else $error("six-bit gamma top bits set");
  property p_b7; reg_rd && reg_addr == 8'hb7 |=> reg_rdata[7:2] == 6'h00; endproperty
  a_b7: assert property (p_b7) else $error("lane count unused bits set");
  property p_b6; reg_wr && reg_addr == 8'hb6 ##1 reg_rd && reg_addr == 8'hb6
    |=> reg_rdata == ($past(reg_wdata, 2) & 8'hfb); endproperty
  a_b6: assert property (p_b6) else $error("pad map readback wrong");
  property p_clk; reg_wr && reg_addr == 8'hb6 && reg_wdata[7] |-> ##2
    lane_pn_swap == $past(reg_wdata[4], 2) && clock_lane_pair_swap == lane_pn_swap; endproperty
  a_clk: assert property (p_clk) else $error("clock pair swap differs");
  property p_cols; h_columns == (res_mode == 2'h0 ? 10'h320 : res_mode == 2'h1 ? 10'h300 :
    res_mode == 2'h2 ? 10'h2d0 : 10'h280); endproperty
  a_cols: assert property (p_cols) else $error("column count wrong");
  property p_unmap; reg_rd && reg_addr == 8'hb4 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_wr: cover property (reg_wr && reg_addr == 8'hb6);
  c_rd: cover property (reg_rd ##1 reg_rdata != 8'h00);
  c_res: cover property (res_mode == 2'h3);
endmodule
bind lpog_bank lpog_bank_checker i_chk (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .lane_pn_swap(lane_pn_swap), .clock_lane_pair_swap(clock_lane_pair_swap),
  .res_mode(res_mode), .h_columns(h_columns));
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for lpog_bank over its strobe port
// assumes the strap model drives the pins
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] strap_cfg = 6'h00;
  logic [7:0] reg_rdata, lane_src_sel;
  logic lane_pn_swap, clock_lane_pair_swap, two_lane_mode, lane_count_strap_pin;
  logic [1:0] res_mode, res_strap_pins;
  logic [9:0] h_columns;
  logic [6:0] pos_gamma_231, pos_gamma_247, pos_gamma_251;
  logic [5:0] pos_gamma_239, pos_gamma_243, pos_gamma_255;
  logic [2:0] lane_map_strap_pins;
  int num_errors = 0;
  int total_checks = 0;
  logic [7:0] adr [8] = '{8'hae, 8'haf, 8'hb0, 8'hb1, 8'hb2, 8'hb3, 8'hb6, 8'hb7};
  logic [7:0] rstv [8] = '{8'h45, 8'h1d, 8'h23, 8'h52, 8'h63, 8'h39, 8'h00, 8'h00};
  logic [7:0] msk [8] = '{8'h7f, 8'h3f, 8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'hfb, 8'h03};
  logic [7:0] ord [4] = '{8'h1b, 8'he4, 8'h93, 8'hc6};
  logic [9:0] cols [4] = '{10'h320, 10'h300, 10'h2d0, 10'h280};
  lpog_strap_model i_strap (.strap_cfg(strap_cfg), .lane_map_strap_pins(lane_map_strap_pins),
    .res_strap_pins(res_strap_pins), .lane_count_strap_pin(lane_count_strap_pin));
  lpog_bank i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_map_strap_pins(lane_map_strap_pins),
    .res_strap_pins(res_strap_pins), .lane_count_strap_pin(lane_count_strap_pin),
    .pos_gamma_231(pos_gamma_231), .pos_gamma_239(pos_gamma_239), .pos_gamma_243(pos_gamma_243),
    .pos_gamma_247(pos_gamma_247), .pos_gamma_251(pos_gamma_251), .pos_gamma_255(pos_gamma_255),
    .lane_src_sel(lane_src_sel), .lane_pn_swap(lane_pn_swap),
    .clock_lane_pair_swap(clock_lane_pair_swap), .res_mode(res_mode), .h_columns(h_columns),
    .two_lane_mode(two_lane_mode));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task chk(input string n, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // a second write waits one edge so its strobe never meets the drop
  task wr(input logic [7:0] a, input logic [7:0] d);
    if (reg_wr) @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", reg_rdata, exp);
    @(posedge clk_sys);
  endtask
  task outs(input logic [2:0] m, input logic [1:0] r, input logic c);
    @(negedge clk_sys);
    chk("lane_src_sel", lane_src_sel, ord[m[2:1]]);
    chk("lane_pn_swap", lane_pn_swap, m[0]);
    chk("res_mode", res_mode, r);
    chk("h_columns", h_columns, cols[r]);
    chk("two_lane_mode", two_lane_mode, c);
    @(posedge clk_sys);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("pos_gamma_231", pos_gamma_231, 7'h45);
    chk("pos_gamma_239", pos_gamma_239, 6'h1d);
    chk("pos_gamma_243", pos_gamma_243, 6'h23);
    chk("pos_gamma_247", pos_gamma_247, 7'h52);
    chk("pos_gamma_251", pos_gamma_251, 7'h63);
    chk("pos_gamma_255", pos_gamma_255, 6'h39);
    for (int i = 0; i < 8; i++) rd(adr[i], rstv[i]);
    outs(3'b000, 2'b00, 1'b0);
    strap_cfg <= 6'b101101;
    repeat (5) @(posedge clk_sys);
    outs(3'b101, 2'b10, 1'b1);
    for (int k = 0; k < 8; k++) begin
      wr(8'hb6, {1'b1, k[2:0], 2'b11, k[1:0]});
      rd(8'hb6, {1'b1, k[2:0], 2'b10, k[1:0]});
      wr(8'hb7, {6'h3f, 1'b1, k[0]});
      rd(8'hb7, {6'h00, 1'b1, k[0]});
      repeat (2) @(posedge clk_sys);
      outs(k[2:0], k[1:0], k[0]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], msk[i]);
    end
    wr(8'hb4, 8'hff);
    rd(8'hb4, 8'h00);
    chk("pos_gamma_231", pos_gamma_231, 7'h7f);
    chk("pos_gamma_239", pos_gamma_239, 6'h3f);
    chk("pos_gamma_243", pos_gamma_243, 6'h3f);
    chk("pos_gamma_247", pos_gamma_247, 7'h7f);
    chk("pos_gamma_251", pos_gamma_251, 7'h7f);
    chk("pos_gamma_255", pos_gamma_255, 6'h3f);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(8'hb6, 8'h00);
    rd(8'hae, 8'h45);
    outs(3'b101, 2'b10, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
